/* File: rtl/rcf_pkg.sv */
// Constants and types shared by the reset-cause flag block.
package rcf_pkg;

	// ----------------------------------------------------------------
	// Register indices (printed offsets) and byte addresses
	// ----------------------------------------------------------------
	localparam logic [19:0] RCF_IDX_CAUSE = 20'hf_ffa8;
	localparam logic [19:0] RCF_IDX_CTRL = 20'hf_ffa9;
	localparam logic [19:0] RCF_IDX_LEVEL = 20'hf_ffaa;
	localparam logic [19:0] RCF_IDX_IRQ_STAT = 20'h0_0010;
	localparam logic [19:0] RCF_IDX_IRQ_MASK = 20'h0_0011;
	localparam logic [31:0] RCF_ADDR_CAUSE = {10'h000, RCF_IDX_CAUSE, 2'b00};
	localparam logic [31:0] RCF_ADDR_CTRL = {10'h000, RCF_IDX_CTRL, 2'b00};
	localparam logic [31:0] RCF_ADDR_LEVEL = {10'h000, RCF_IDX_LEVEL, 2'b00};
	localparam logic [31:0] RCF_ADDR_IRQ_STAT = {10'h000, RCF_IDX_IRQ_STAT, 2'b00};
	localparam logic [31:0] RCF_ADDR_IRQ_MASK = {10'h000, RCF_IDX_IRQ_MASK, 2'b00};

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int RCF_BIT_LOW_VOLTAGE = 0;
	localparam int RCF_BIT_BAD_ACCESS = 1;
	localparam int RCF_BIT_RAM_PARITY = 2;
	localparam int RCF_BIT_WATCHDOG = 4;
	localparam int RCF_BIT_ILLEGAL_INSTR = 7;
	localparam int RCF_BIT_LV_FLAG = 0;
	localparam int RCF_BIT_LV_MASK = 1;
	localparam int RCF_BIT_LEVEL_WE = 7;

	// ----------------------------------------------------------------
	// Reset values and bus codes
	// ----------------------------------------------------------------
	localparam logic [7:0] RCF_CAUSE_RST = 8'h00;
	localparam logic [7:0] RCF_CTRL_RST = 8'h00;
	localparam logic [7:0] RCF_LEVEL_RST = 8'h00;
	localparam logic [7:0] RCF_IRQ_RST = 8'h00;
	localparam logic [1:0] RCF_RESP_OKAY = 2'b00;
	localparam logic [1:0] RCF_RESP_SLVERR = 2'b10;

	// Reset sources, one bit each
	typedef struct packed {
		logic pin;
		logic por;
		logic illegal_instr;
		logic watchdog;
		logic ram_parity;
		logic bad_access;
		logic low_voltage;
	} rcf_src_t;

endpackage : rcf_pkg

/* File: rtl/rcf_reset_cause.sv */
// Reset-cause flags, voltage detection registers and AXI4-Lite slave.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

// Summary of operation
// R1 - Pin/POR reset clears the illegal-instruction flag, its own reset sets it, others keep it.
// R2 - Pin/POR reset clears the watchdog flag, a watchdog reset sets it, others keep it.
// R3 - Pin/POR reset clears the RAM parity flag, a parity reset sets it, others keep it.
// R4 - Pin/POR reset clears the bad-access flag, a bad-access reset sets it, others keep it.
// R5 - Pin/POR reset clears the low-voltage flag, a detector reset sets it, others keep it.
// R6 - The level write enable clears on every reset source except the detector, which keeps it.
// R7 - The cause register is an 8-bit read-only byte register at its fixed address.
// R8 - The control register is read/write and resets to 00H except for the bits held per source.
// R9 - The level register is read/write and resets to its fixed choice of 00H, 01H or 81H; arst_n always loads 00H, only source events load LEVEL_RESET.
module rcf_reset_cause #(
	parameter logic [7:0] LEVEL_RESET = rcf_pkg::RCF_LEVEL_RST
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire rcf_pkg::rcf_src_t reset_src,
	input wire logic low_voltage_detector,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [7:0] voltage_detect_level,
	output logic level_write_enable,
	output logic irq
);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	rcf_pkg::rcf_src_t src_s1_r;
	rcf_pkg::rcf_src_t src_s2_r;
	rcf_pkg::rcf_src_t src_s3_r;
	rcf_pkg::rcf_src_t src_ev;
	logic lvd_s1_r;
	logic lvd_s2_r;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			src_s1_r <= '0;
			src_s2_r <= '0;
			src_s3_r <= '0;
			lvd_s1_r <= 1'b0;
			lvd_s2_r <= 1'b0;
		end else if (ce) begin
			src_s1_r <= reset_src;
			src_s2_r <= src_s1_r;
			src_s3_r <= src_s2_r;
			lvd_s1_r <= low_voltage_detector;
			lvd_s2_r <= lvd_s1_r;
		end
	end

	// A source counts once, on its rising edge
	assign src_ev = src_s2_r & ~src_s3_r;

	logic ev_clear;
	logic ev_not_lvd;
	assign ev_clear = src_ev.pin | src_ev.por;
	assign ev_not_lvd = src_ev.pin | src_ev.por | src_ev.illegal_instr | src_ev.watchdog
		| src_ev.ram_parity | src_ev.bad_access;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic [31:0] aw_addr_r;
	logic aw_held_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic w_held_r;
	logic wr_go;
	logic wr_lane0;
	logic wr_ro;
	logic wr_hit;
	logic wr_ctrl;
	logic wr_level;
	logic wr_stat;
	logic wr_mask;

	assign wr_go = aw_held_r & w_held_r & ~s_axi_bvalid;
	assign wr_lane0 = w_strb_r[0];
	assign wr_ctrl = wr_go & wr_lane0 & (aw_addr_r == rcf_pkg::RCF_ADDR_CTRL);
	assign wr_level = wr_go & wr_lane0 & (aw_addr_r == rcf_pkg::RCF_ADDR_LEVEL);
	assign wr_stat = wr_go & wr_lane0 & (aw_addr_r == rcf_pkg::RCF_ADDR_IRQ_STAT);
	assign wr_mask = wr_go & wr_lane0 & (aw_addr_r == rcf_pkg::RCF_ADDR_IRQ_MASK);
	// Cause register takes no writes
	assign wr_ro = aw_addr_r == rcf_pkg::RCF_ADDR_CAUSE; // R7
	assign wr_hit = (aw_addr_r == rcf_pkg::RCF_ADDR_CTRL) | (aw_addr_r == rcf_pkg::RCF_ADDR_LEVEL)
		| (aw_addr_r == rcf_pkg::RCF_ADDR_IRQ_STAT) | (aw_addr_r == rcf_pkg::RCF_ADDR_IRQ_MASK);

	// ----------------------------------------------------------------
	// Cause flags
	// ----------------------------------------------------------------
	logic [7:0] cause_r;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cause_r <= rcf_pkg::RCF_CAUSE_RST;
		end else if (ce) begin
			if (ev_clear) begin
				cause_r <= 8'h00; // R1 R2 R3 R4 R5
			end else begin
				if (src_ev.illegal_instr) begin
					cause_r[rcf_pkg::RCF_BIT_ILLEGAL_INSTR] <= 1'b1; // R1
				end
				if (src_ev.watchdog) begin
					cause_r[rcf_pkg::RCF_BIT_WATCHDOG] <= 1'b1; // R2
				end
				if (src_ev.ram_parity) begin
					cause_r[rcf_pkg::RCF_BIT_RAM_PARITY] <= 1'b1; // R3
				end
				if (src_ev.bad_access) begin
					cause_r[rcf_pkg::RCF_BIT_BAD_ACCESS] <= 1'b1; // R4
				end
				if (src_ev.low_voltage) begin
					cause_r[rcf_pkg::RCF_BIT_LOW_VOLTAGE] <= 1'b1; // R5
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Voltage detection control and level
	// ----------------------------------------------------------------
	logic lv_mask_r;
	logic lv_flag_r;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			level_write_enable <= rcf_pkg::RCF_CTRL_RST[rcf_pkg::RCF_BIT_LEVEL_WE];
			lv_mask_r <= rcf_pkg::RCF_CTRL_RST[rcf_pkg::RCF_BIT_LV_MASK]; // R8
		end else if (ce) begin
			if (ev_not_lvd) begin
				level_write_enable <= 1'b0; // R6
			end else if (wr_ctrl) begin
				level_write_enable <= w_data_r[rcf_pkg::RCF_BIT_LEVEL_WE]; // R8
			end
			// Mask is held across every source
			if (wr_ctrl) begin
				lv_mask_r <= w_data_r[rcf_pkg::RCF_BIT_LV_MASK];
			end
		end
	end

	// Live detector state, read-only
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lv_flag_r <= 1'b0;
		end else if (ce) begin
			lv_flag_r <= lvd_s2_r;
		end
	end

	// Level writes only take while the enable is set, guarding the trip point; any source event reloads LEVEL_RESET
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			voltage_detect_level <= rcf_pkg::RCF_LEVEL_RST;
		end else if (ce) begin
			if (src_ev != '0) begin
				voltage_detect_level <= LEVEL_RESET; // R9
			end else if (wr_level && level_write_enable) begin
				voltage_detect_level <= w_data_r[7:0]; // R9
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status and mask
	// ----------------------------------------------------------------
	logic [7:0] irq_stat_r;
	logic [7:0] irq_mask_r;
	logic [7:0] irq_set;
	logic [7:0] stat_nxt;

	always_comb begin
		irq_set = 8'h00;
		if (!ev_clear) begin
			irq_set[rcf_pkg::RCF_BIT_ILLEGAL_INSTR] = src_ev.illegal_instr;
			irq_set[rcf_pkg::RCF_BIT_WATCHDOG] = src_ev.watchdog;
			irq_set[rcf_pkg::RCF_BIT_RAM_PARITY] = src_ev.ram_parity;
			irq_set[rcf_pkg::RCF_BIT_BAD_ACCESS] = src_ev.bad_access;
			irq_set[rcf_pkg::RCF_BIT_LOW_VOLTAGE] = src_ev.low_voltage;
		end
		// Set beats a simultaneous write-one-to-clear
		stat_nxt = (irq_stat_r & ~(wr_stat ? w_data_r[7:0] : 8'h00)) | irq_set;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_stat_r <= rcf_pkg::RCF_IRQ_RST;
			irq_mask_r <= rcf_pkg::RCF_IRQ_RST;
			irq <= 1'b0;
		end else if (ce) begin
			irq_stat_r <= stat_nxt;
			if (wr_mask) begin
				irq_mask_r <= w_data_r[7:0];
			end
			irq <= |(stat_nxt & irq_mask_r);
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_addr_r <= 32'h0000_0000;
			aw_held_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			w_held_r <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= rcf_pkg::RCF_RESP_OKAY;
		end else if (ce) begin
			s_axi_awready <= ~aw_held_r & ~(s_axi_awvalid & s_axi_awready);
			s_axi_wready <= ~w_held_r & ~(s_axi_wvalid & s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_r <= {s_axi_awaddr[31:2], 2'b00};
				aw_held_r <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
				w_held_r <= 1'b1;
			end
			if (wr_go) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_hit && !wr_ro) ? rcf_pkg::RCF_RESP_OKAY
					: rcf_pkg::RCF_RESP_SLVERR; // R7
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	logic [7:0] rd_byte;
	logic rd_hit;
	logic [31:0] rd_addr;

	always_comb begin
		rd_addr = {s_axi_araddr[31:2], 2'b00};
		rd_hit = 1'b1;
		rd_byte = 8'h00;
		unique case (rd_addr)
			rcf_pkg::RCF_ADDR_CAUSE: begin
				rd_byte = cause_r; // R7
			end
			rcf_pkg::RCF_ADDR_CTRL: begin
				rd_byte[rcf_pkg::RCF_BIT_LEVEL_WE] = level_write_enable;
				rd_byte[rcf_pkg::RCF_BIT_LV_MASK] = lv_mask_r;
				rd_byte[rcf_pkg::RCF_BIT_LV_FLAG] = lv_flag_r; // R8
			end
			rcf_pkg::RCF_ADDR_LEVEL: begin
				rd_byte = voltage_detect_level; // R9
			end
			rcf_pkg::RCF_ADDR_IRQ_STAT: begin
				rd_byte = irq_stat_r;
			end
			rcf_pkg::RCF_ADDR_IRQ_MASK: begin
				rd_byte = irq_mask_r;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= rcf_pkg::RCF_RESP_OKAY;
		end else if (ce) begin
			// One read in flight; arready drops while an answer waits
			s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h00_0000, rd_byte};
				s_axi_rresp <= rd_hit ? rcf_pkg::RCF_RESP_OKAY : rcf_pkg::RCF_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule : rcf_reset_cause

/* File: testbench/rcf_reset_cause_monitor.sv */
// Port-level checker for the reset-cause block.
`timescale 1ns/1ps
module rcf_reset_cause_monitor #(
	parameter logic [7:0] LEVEL_RESET = rcf_pkg::RCF_LEVEL_RST
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire rcf_pkg::rcf_src_t reset_src,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic [7:0] voltage_detect_level,
	input wire logic level_write_enable
);
// ----------
// Cause model
// ----------
logic [6:0] s1_r, s2_r, s3_r, ev;
logic [7:0] cause_r, rcap_r;
logic [31:0] aw_r, ar_r;
logic rd_cause;
assign ev = s2_r & ~s3_r;
assign rd_cause = ar_r == rcf_pkg::RCF_ADDR_CAUSE;
// Same two-flop sync depth as the block, so flags line up by edge
always_ff @(posedge clk or negedge arst_n) begin
	if (!arst_n) begin
		s1_r <= '0;
		s2_r <= '0;
		s3_r <= '0;
		cause_r <= 8'h00;
	end else if (ce) begin
		s1_r <= reset_src;
		s2_r <= s1_r;
		s3_r <= s2_r;
		cause_r <= (ev[6] | ev[5]) ? 8'h00 : cause_r | {ev[4], 2'b00, ev[3], 1'b0, ev[2:0]};
	end
end
always_ff @(posedge clk or negedge arst_n) begin
	if (!arst_n) begin
		aw_r <= '0;
		ar_r <= '0;
		rcap_r <= 8'h00;
	end else if (ce) begin
		if (s_axi_awvalid && s_axi_awready) aw_r <= s_axi_awaddr;
		if (s_axi_arvalid && s_axi_arready) begin
			ar_r <= s_axi_araddr;
			rcap_r <= cause_r;
		end
	end
end
// ----------
// Assertions
// ----------
default clocking @(posedge clk); endclocking
default disable iff (!arst_n || !ce);
a_trap_flag: assert property (
	s_axi_rvalid && rd_cause |-> s_axi_rdata[7] == rcap_r[7]) else $error("trap flag wrong");
a_wdog_flag: assert property (
	s_axi_rvalid && rd_cause |-> s_axi_rdata[4] == rcap_r[4]) else $error("watchdog flag wrong");
a_parity_flag: assert property (
	s_axi_rvalid && rd_cause |-> s_axi_rdata[2] == rcap_r[2]) else $error("parity flag wrong");
a_access_flag: assert property (
	s_axi_rvalid && rd_cause |-> s_axi_rdata[1] == rcap_r[1]) else $error("access flag wrong");
a_lowv_flag: assert property (
	s_axi_rvalid && rd_cause |-> s_axi_rdata[0] == rcap_r[0]) else $error("low-voltage flag wrong");
a_lwe_cleared: assert property (
	$rose(|reset_src[6:1]) |-> ##3 !level_write_enable) else $error("enable not cleared");
a_lwe_held: assert property (
	$rose(reset_src.low_voltage) && !(|reset_src[6:1]) && level_write_enable
	|=> level_write_enable [*4]) else $error("enable not held");
a_cause_ro: assert property (
	s_axi_bvalid && aw_r == rcf_pkg::RCF_ADDR_CAUSE |-> s_axi_bresp == rcf_pkg::RCF_RESP_SLVERR)
	else $error("cause write accepted");
a_level_reset: assert property (
	$rose(reset_src.por) |-> ##3 voltage_detect_level == LEVEL_RESET)
	else $error("level reset wrong");
endmodule : rcf_reset_cause_monitor

/* File: testbench/tb_rcf_reset_cause.sv */
// Self-checking bench for the reset-cause block.
`timescale 1ns/1ps
module tb_rcf_reset_cause;
localparam logic [7:0] LR = 8'h81;
localparam logic [31:0] CA = rcf_pkg::RCF_ADDR_CAUSE;
localparam logic [31:0] CT = rcf_pkg::RCF_ADDR_CTRL;
localparam logic [31:0] LV = rcf_pkg::RCF_ADDR_LEVEL;
localparam logic [31:0] ST = rcf_pkg::RCF_ADDR_IRQ_STAT;
localparam logic [31:0] MK = rcf_pkg::RCF_ADDR_IRQ_MASK;
localparam logic [1:0] OK = rcf_pkg::RCF_RESP_OKAY;
localparam logic [1:0] ER = rcf_pkg::RCF_RESP_SLVERR;
logic clk = 1'b0;
logic arst_n = 1'b0;
logic ce = 1'b1;
logic low_voltage_detector = 1'b0;
rcf_pkg::rcf_src_t reset_src = '0;
logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
logic [3:0] s_axi_wstrb = 4'h1;
logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire logic [1:0] s_axi_bresp, s_axi_rresp;
wire logic [31:0] s_axi_rdata;
wire logic [7:0] voltage_detect_level;
wire logic level_write_enable, irq;
int n_errors = 0;
int samples_checked = 0;
int i;
logic [7:0] exp_c, lv_v;
always #2 clk = ~clk;
rcf_reset_cause #(.LEVEL_RESET(LR)) dut (.clk, .arst_n, .ce, .reset_src,
	.low_voltage_detector, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
	.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .voltage_detect_level, .level_write_enable, .irq);
// ----------
// Tasks
// ----------
task automatic close_out();
	if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
	else $display("Some tests failed");
	$finish;
endtask : close_out
task automatic chk(input logic [31:0] g, input logic [31:0] e);
	samples_checked++;
	if (g !== e) begin
		n_errors++;
		$display("unexpected at %0t: got %h want %h", $time, g, e);
	end
endtask : chk
task automatic tmo(input int n);
	if (n >= 40) begin
		n_errors++;
		close_out();
	end
endtask : tmo
task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [3:0] s,
	input logic [1:0] er);
	int n = 0;
	logic ad = 1'b0;
	logic wd = 1'b0;
	@(posedge clk);
	s_axi_awaddr <= a;
	s_axi_wdata <= {24'h00_0000, d};
	s_axi_wstrb <= s;
	s_axi_awvalid <= 1'b1;
	s_axi_wvalid <= 1'b1;
	s_axi_bready <= 1'b1;
	while (!(ad && wd) && n < 40) begin
		@(posedge clk);
		n++;
		if (s_axi_awvalid && s_axi_awready) begin
			ad = 1'b1;
			s_axi_awvalid <= 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wd = 1'b1;
			s_axi_wvalid <= 1'b0;
		end
	end
	while (!s_axi_bvalid && n < 40) begin
		@(posedge clk);
		n++;
	end
	s_axi_bready <= 1'b0;
	tmo(n);
	chk({30'h0, s_axi_bresp}, {30'h0, er});
endtask : wr
task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
	int n = 0;
	@(posedge clk);
	s_axi_araddr <= a;
	s_axi_arvalid <= 1'b1;
	s_axi_rready <= 1'b1;
	do begin
		@(posedge clk);
		n++;
	end while (!s_axi_arready && n < 40);
	s_axi_arvalid <= 1'b0;
	while (!s_axi_rvalid && n < 40) begin
		@(posedge clk);
		n++;
	end
	s_axi_rready <= 1'b0;
	tmo(n);
	chk(s_axi_rdata, e);
	chk({30'h0, s_axi_rresp}, {30'h0, er});
endtask : rd
// Source held one cycle, then low so the next pulse re-triggers
task automatic pulse(input logic [6:0] m);
	@(posedge clk);
	reset_src <= m;
	@(posedge clk);
	reset_src <= '0;
	repeat (6) @(posedge clk);
endtask : pulse
function automatic logic [7:0] cbit(input int k);
	return k == 4 ? 8'h80 : k == 3 ? 8'h10 : 8'h01 << k;
endfunction : cbit
// ----------
// Sequence
// ----------
initial begin
	void'($urandom(18660));
	repeat (12) @(posedge clk);
	arst_n <= 1'b1;
	rd(CA, '0, OK);
	rd(CT, '0, OK);
	rd(LV, '0, OK);
	wr(CA, 8'hff, 4'h1, ER);
	rd(CA, '0, OK);
	rd(32'h0000_0100, '0, ER);
	wr(CT, 8'h80, 4'h1, OK);
	rd(CT, 32'h0000_0080, OK);
	lv_v = 8'($urandom);
	wr(LV, lv_v, 4'h1, OK);
	wr(LV, ~lv_v, 4'h0, OK);
	rd(LV, {24'h00_0000, lv_v}, OK);
	exp_c = 8'h00;
	for (int k = 0; k < 11; k++) begin
		i = k < 5 ? k : $urandom_range(4, 0);
		wr(CT, 8'h80, 4'h1, OK);
		pulse(7'h01 << i);
		exp_c |= cbit(i);
		rd(CA, {24'h00_0000, exp_c}, OK);
		chk({31'h0, level_write_enable}, {31'h0, i == 0});
		chk({24'h00_0000, voltage_detect_level}, {24'h00_0000, LR});
	end
	pulse(7'h40);
	rd(CA, '0, OK);
	wr(CT, 8'h80, 4'h1, OK);
	pulse(7'h28);
	rd(CA, '0, OK);
	chk({31'h0, level_write_enable}, 32'h0000_0000);
	wr(LV, 8'h5a, 4'h1, OK);
	rd(LV, {24'h00_0000, LR}, OK);
	wr(CT, 8'h82, 4'h1, OK);
	pulse(7'h40);
	rd(CT, 32'h0000_0002, OK);
	// Frozen block must miss a source that comes and goes while ce is low
	ce <= 1'b0;
	pulse(7'h10);
	ce <= 1'b1;
	rd(CA, '0, OK);
	wr(ST, 8'hff, 4'h1, OK);
	wr(MK, 8'h10, 4'h1, OK);
	pulse(7'h08);
	chk({31'h0, irq}, 32'h0000_0001);
	rd(ST, 32'h0000_0010, OK);
	rd(MK, 32'h0000_0010, OK);
	wr(MK, 8'h00, 4'h1, OK);
	repeat (2) @(posedge clk);
	chk({31'h0, irq}, 32'h0000_0000);
	wr(MK, 8'h10, 4'h1, OK);
	repeat (2) @(posedge clk);
	chk({31'h0, irq}, 32'h0000_0001);
	wr(ST, 8'h10, 4'h1, OK);
	repeat (2) @(posedge clk);
	chk({31'h0, irq}, 32'h0000_0000);
	low_voltage_detector <= 1'b1;
	repeat (4) @(posedge clk);
	rd(CT, 32'h0000_0003, OK);
	close_out();
end
endmodule : tb_rcf_reset_cause
bind rcf_reset_cause rcf_reset_cause_monitor #(.LEVEL_RESET(LEVEL_RESET)) u_mon (.clk,
	.arst_n, .ce, .reset_src, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_bresp, .s_axi_bvalid, .s_axi_rdata,
	.s_axi_rvalid, .voltage_detect_level, .level_write_enable);
